// ---- src/ppss_sequencer.sv ----
// ppss_sequencer: power-state sequencer of a single-pair ethernet phy.
// assumes media status inputs come from same-clock pcs/pma logic;
// wake and bootstrap pins are asynchronous and synchronised here.
//
// Summary of operation
// - autonomous strap: standby to normal after por
// - managed: media energy moves standby to normal
// - writing autonomous bit 6 leaves standby
// - power mode bit 0 forces normal from standby or sleep request
// - never normal or sleep request to standby
// - received sleep code-groups enter sleep request
// - power mode bit 1 starts sleep code-groups
// - frame before timer expiry returns to normal
// - sleep codes plus expired timer enter silent
// - quiet zero-symbol line also enters silent
// - silent entered only with wake low
// - sleep disabled: silent timer expiry to standby
// - non-quiet codes before expiry to standby
// - sleep enabled: expiry or no activity sleeps
// - sleep-request timer starts on entry, 1 ms
// - silent timer runs 8 ms
// - sleep loses registers, management unavailable
// - wake high or energy leaves sleep
`default_nettype none
module ppss_sequencer
  import ppss_pkg::*;
#(
  parameter int SLEEP_RQST_CYCLES = PPSS_SLEEP_RQST_CYC,
  parameter int SILENT_CYCLES     = PPSS_SILENT_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wake_pin,
  input  wire logic        auton_strap_pin,
  input  wire logic        por_done,
  input  wire logic        energy_det,
  input  wire logic        lps_rx_valid,
  input  wire logic        quiet_rx,
  input  wire logic        non_quiet_rx,
  input  wire logic        frame_tx,
  input  wire logic        frame_rx,
  input  wire logic        tx_activity,
  input  wire logic        rx_activity,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic      [2:0]  power_state,
  output logic             pcs_pma_en,
  output logic             lps_tx_en,
  output logic             send_quiet,
  output logic             mgmt_avail
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  localparam logic [PPSS_TMR_W-1:0] SRQ_LIM = PPSS_TMR_W'(SLEEP_RQST_CYCLES - 1);
  localparam logic [PPSS_TMR_W-1:0] SIL_LIM = PPSS_TMR_W'(SILENT_CYCLES - 1);

  ppss_state_e             state, next_state;
  logic [1:0]              wake_ff, next_wake_ff;
  logic [1:0]              strap_ff, next_strap_ff;
  logic                    strap_loaded, next_strap_loaded;
  logic [15:0]             auto_reg, next_auto_reg;
  logic [15:0]             power_mode_control_reg, next_power_mode_control_reg;
  logic [15:0]             lctl2_reg, next_lctl2_reg;
  logic [15:0]             lcfg_reg, next_lcfg_reg;
  logic [PPSS_TMR_W-1:0]   tmr, next_tmr;
  logic [15:0]             next_reg_rdata;
  logic                    wake_s, lps_ok, tmr_exp, sleep_en, wr_ok;

  // pin synchronisers; only the second stage is read
  always_comb begin
    next_wake_ff  = {wake_ff[0], wake_pin};
    next_strap_ff = {strap_ff[0], auton_strap_pin};
  end
  assign wake_s = wake_ff[1];

  // synchronisers carry no reset: they flush while rst_n is held, so the
  // strap is already settled when it is caught after release
  always_ff @(posedge clk) begin
    wake_ff  <= next_wake_ff;
    strap_ff <= next_strap_ff;
  end

  // sleep code-groups count only with recognition and stream set up
  assign lps_ok   = lps_rx_valid && lctl2_reg[PPSS_LCTL2_ID_BIT]
                    && (lcfg_reg[PPSS_LCFG_SCR_LSB +: 2] == PPSS_LCFG_SCR_SEL);
  assign sleep_en = auto_reg[PPSS_AUTO_SLEEP_BIT];
  assign tmr_exp  = (state == PPSS_SLPREQ) ? (tmr == SRQ_LIM) : (tmr == SIL_LIM);
  assign wr_ok    = reg_wr && (state != PPSS_SLEEP);

  // state transitions
  always_comb begin
    next_state = state;
    case (state)
      PPSS_STANDBY: begin
        if (auto_reg[PPSS_AUTO_AUTON_BIT] && strap_loaded && por_done) begin
          next_state = PPSS_NORMAL;
        end else if (energy_det || power_mode_control_reg[PPSS_POWER_MODE_CONTROL_NORMAL_BIT]) begin
          next_state = PPSS_NORMAL;
        end
      end
      PPSS_NORMAL: begin
        // no standby path; sleep request entry
        if (lps_ok || power_mode_control_reg[PPSS_POWER_MODE_CONTROL_SLEEP_BIT]) begin
          next_state = PPSS_SLPREQ;
        end
      end
      PPSS_SLPREQ: begin
        if (power_mode_control_reg[PPSS_POWER_MODE_CONTROL_NORMAL_BIT] || ((frame_tx || frame_rx) && !tmr_exp)) begin
          next_state = PPSS_NORMAL;
        end else if (!wake_s && ((lps_ok && tmr_exp) || quiet_rx)) begin
          next_state = PPSS_SILENT;
        end
      end
      PPSS_SILENT: begin
        if (non_quiet_rx && !tmr_exp) begin
          next_state = PPSS_STANDBY;
        end else if (!sleep_en && tmr_exp) begin
          next_state = PPSS_STANDBY;
        end else if (sleep_en && (tmr_exp || !(tx_activity || rx_activity))) begin
          next_state = PPSS_SLEEP;
        end
      end
      PPSS_SLEEP: begin
        if (wake_s || energy_det) begin
          next_state = PPSS_STANDBY;
        end
      end
      default: next_state = PPSS_STANDBY;
    endcase
  end

  // shared timer; holds at its limit so expiry stays visible
  always_comb begin
    if (next_state != state) begin
      next_tmr = '0;
    end else if (!tmr_exp) begin
      next_tmr = tmr + 1'b1;
    end else begin
      next_tmr = tmr;
    end
  end

  // management registers; a write beats the hardware clear
  always_comb begin
    next_auto_reg     = auto_reg;
    next_power_mode_control_reg     = power_mode_control_reg;
    next_lctl2_reg    = lctl2_reg;
    next_lcfg_reg     = lcfg_reg;
    next_strap_loaded = strap_loaded;
    // strap caught once por is done, not at reset itself
    if (!strap_loaded && por_done) begin
      next_auto_reg[PPSS_AUTO_AUTON_BIT] = strap_ff[1];
      next_strap_loaded                  = 1'b1;
    end
    // force-normal request is consumed on reaching normal
    if (state == PPSS_NORMAL) begin
      next_power_mode_control_reg[PPSS_POWER_MODE_CONTROL_NORMAL_BIT] = 1'b0;
    end
    // sleep request is consumed once silent is reached
    if (state == PPSS_SILENT) begin
      next_power_mode_control_reg[PPSS_POWER_MODE_CONTROL_SLEEP_BIT] = 1'b0;
    end
    if (wr_ok) begin
      case (reg_addr)
        PPSS_AUTO_OFS:  next_auto_reg  = reg_wdata;
        PPSS_POWER_MODE_CONTROL_OFS:  next_power_mode_control_reg  = {12'h000, reg_wdata[3:0]};
        PPSS_LCTL2_OFS: next_lctl2_reg = reg_wdata;
        PPSS_LCFG_OFS:  next_lcfg_reg  = reg_wdata;
        default: ;
      endcase
    end
    // contents lost in sleep; strap taken again on wake
    if (state == PPSS_SLEEP) begin
      next_auto_reg     = PPSS_AUTO_RST;
      next_power_mode_control_reg     = PPSS_POWER_MODE_CONTROL_RST;
      next_lctl2_reg    = PPSS_LCTL2_RST;
      next_lcfg_reg     = PPSS_LCFG_RST;
      next_strap_loaded = 1'b0;
    end
  end

  // read data; unmapped offsets and sleep read zero
  always_comb begin
    next_reg_rdata = 16'h0000;
    if (reg_rd && state != PPSS_SLEEP) begin
      case (reg_addr)
        PPSS_AUTO_OFS:  next_reg_rdata = auto_reg;
        PPSS_POWER_MODE_CONTROL_OFS:  next_reg_rdata = {9'h000, 3'(state), power_mode_control_reg[3:0]};
        PPSS_LCTL2_OFS: next_reg_rdata = lctl2_reg;
        PPSS_LCFG_OFS:  next_reg_rdata = lcfg_reg;
        default:        next_reg_rdata = 16'h0000;
      endcase
    end
  end

  // registers, synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state        <= PPSS_STANDBY;
      strap_loaded <= 1'b0;
      auto_reg     <= PPSS_AUTO_RST;
      power_mode_control_reg     <= PPSS_POWER_MODE_CONTROL_RST;
      lctl2_reg    <= PPSS_LCTL2_RST;
      lcfg_reg     <= PPSS_LCFG_RST;
      tmr          <= '0;
      reg_rdata    <= 16'h0000;
      power_state  <= 3'h0;
      pcs_pma_en   <= 1'b0;
      lps_tx_en    <= 1'b0;
      send_quiet   <= 1'b0;
      mgmt_avail   <= 1'b0;
    end else begin
      state        <= next_state;
      strap_loaded <= next_strap_loaded;
      auto_reg     <= next_auto_reg;
      power_mode_control_reg     <= next_power_mode_control_reg;
      lctl2_reg    <= next_lctl2_reg;
      lcfg_reg     <= next_lcfg_reg;
      tmr          <= next_tmr;
      reg_rdata    <= next_reg_rdata;
      power_state  <= 3'(next_state);
      pcs_pma_en   <= (next_state == PPSS_NORMAL) || (next_state == PPSS_SLPREQ);
      // sleep code-groups need the transmit enable too
      lps_tx_en    <= (next_state == PPSS_SLPREQ) && next_auto_reg[PPSS_AUTO_LPS_TX_BIT]
                      && next_power_mode_control_reg[PPSS_POWER_MODE_CONTROL_SLEEP_BIT];
      send_quiet   <= (next_state == PPSS_SILENT);
      mgmt_avail   <= (next_state != PPSS_SLEEP);
    end
  end

  // checks
  a_no_standby_path: assert property (
    (state == PPSS_NORMAL || state == PPSS_SLPREQ) |=> state != PPSS_STANDBY)
    else $error("standby reached from normal or sleep request");
  a_auto_to_normal: assert property (
    (state == PPSS_STANDBY && auto_reg[PPSS_AUTO_AUTON_BIT] && strap_loaded && por_done)
    |=> state == PPSS_NORMAL ##0 pcs_pma_en)
    else $error("autonomous standby exit missed");
  a_energy_wakes: assert property (
    (state == PPSS_STANDBY && energy_det) |=> power_state == 3'(PPSS_NORMAL))
    else $error("energy did not leave standby");
  a_force_normal: assert property (
    ((state == PPSS_STANDBY || state == PPSS_SLPREQ) && power_mode_control_reg[PPSS_POWER_MODE_CONTROL_NORMAL_BIT])
    |=> state == PPSS_NORMAL)
    else $error("force normal ignored");
  a_lps_entry: assert property (
    (state == PPSS_NORMAL && lps_ok) |=> state == PPSS_SLPREQ && tmr == 0)
    else $error("sleep request entry or timer start wrong");
  a_frame_return: assert property (
    (state == PPSS_SLPREQ && frame_rx && tmr < SRQ_LIM) |=> state == PPSS_NORMAL)
    else $error("frame did not end sleep request");
  a_silent_wake_low: assert property (
    $rose(state == PPSS_SILENT) |-> !$past(wake_s) ##0 send_quiet)
    else $error("silent entered with wake high");
  a_quiet_silent: assert property (
    (state == PPSS_SLPREQ && quiet_rx && !wake_s && !frame_tx && !frame_rx
     && !power_mode_control_reg[PPSS_POWER_MODE_CONTROL_NORMAL_BIT]) |=> state == PPSS_SILENT)
    else $error("quiet line did not enter silent");
  a_silent_standby: assert property (
    (state == PPSS_SILENT && !sleep_en && tmr == SIL_LIM) |=> state == PPSS_STANDBY)
    else $error("silent expiry with sleep off did not reach standby");
  a_silent_activity: assert property (
    (state == PPSS_SILENT && non_quiet_rx && tmr != SIL_LIM) |=> state == PPSS_STANDBY)
    else $error("line activity in silent ignored");
  a_silent_sleep: assert property (
    (state == PPSS_SILENT && sleep_en && !non_quiet_rx && !tx_activity && !rx_activity)
    |=> state == PPSS_SLEEP ##1 (!mgmt_avail && auto_reg == PPSS_AUTO_RST))
    else $error("sleep entry or register loss wrong");
  a_sleep_wake: assert property (
    (state == PPSS_SLEEP && (wake_s || energy_det)) |=> state == PPSS_STANDBY)
    else $error("wake did not leave sleep");
  a_lps_tx_on: assert property (
    (state == PPSS_NORMAL && auto_reg[PPSS_AUTO_LPS_TX_BIT] && power_mode_control_reg[PPSS_POWER_MODE_CONTROL_SLEEP_BIT]
     && !wr_ok) |=> state == PPSS_SLPREQ && lps_tx_en)
    else $error("sleep code-groups not sent");
  a_timer_restart: assert property (
    (state != $past(state)) |-> tmr == 0)
    else $error("timer not restarted on entry");

  c_full_sleep: cover property (state == PPSS_SILENT ##1 state == PPSS_SLEEP);
  c_srq_abort: cover property (state == PPSS_SLPREQ ##1 state == PPSS_NORMAL);
  c_srq_expire: cover property (state == PPSS_SLPREQ && tmr == SRQ_LIM);
  c_sleep_wake: cover property (state == PPSS_SLEEP ##1 state == PPSS_STANDBY);
endmodule : ppss_sequencer
`default_nettype wire

// ---- src/ppss_pkg.sv ----
// ppss_pkg: constants shared by the power-state sequencer.
// assumes a 20 MHz core clock and a 16-bit management register port.
`default_nettype none
package ppss_pkg;
  // power states
  typedef enum logic [2:0] {
    PPSS_STANDBY = 3'b000,
    PPSS_NORMAL  = 3'b001,
    PPSS_SLPREQ  = 3'b010,
    PPSS_SILENT  = 3'b011,
    PPSS_SLEEP   = 3'b100
  } ppss_state_e;

  // register offsets
  localparam logic [15:0] PPSS_AUTO_OFS  = 16'h018b;
  localparam logic [15:0] PPSS_POWER_MODE_CONTROL_OFS  = 16'h018c;
  localparam logic [15:0] PPSS_LCTL2_OFS = 16'h0487;
  localparam logic [15:0] PPSS_LCFG_OFS  = 16'h04e5;

  // field positions
  localparam int PPSS_AUTO_LPS_TX_BIT = 0;
  localparam int PPSS_AUTO_SLEEP_BIT  = 1;
  localparam int PPSS_AUTO_AUTON_BIT  = 6;
  localparam int PPSS_POWER_MODE_CONTROL_NORMAL_BIT = 0;
  localparam int PPSS_POWER_MODE_CONTROL_SLEEP_BIT  = 1;
  localparam int PPSS_POWER_MODE_CONTROL_STATE_LSB  = 4;
  localparam int PPSS_LCTL2_ID_BIT    = 0;
  localparam int PPSS_LCFG_SCR_LSB    = 8;
  localparam logic [1:0] PPSS_LCFG_SCR_SEL = 2'h3;

  // values after reset; sleep enable defaults on
  localparam logic [15:0] PPSS_AUTO_RST  = 16'h0002;
  localparam logic [15:0] PPSS_POWER_MODE_CONTROL_RST  = 16'h0000;
  localparam logic [15:0] PPSS_LCTL2_RST = 16'h0000;
  localparam logic [15:0] PPSS_LCFG_RST  = 16'h0000;

  // timing
  localparam int PPSS_CLK_HZ          = 20_000_000;
  localparam int PPSS_SLEEP_RQST_US   = 1000;
  localparam int PPSS_SILENT_US       = 8000;
  localparam int PPSS_SLEEP_RQST_CYC  = PPSS_CLK_HZ / 1_000_000 * PPSS_SLEEP_RQST_US;
  localparam int PPSS_SILENT_CYC      = PPSS_CLK_HZ / 1_000_000 * PPSS_SILENT_US;
  localparam int PPSS_TMR_W           = 18;
endpackage : ppss_pkg
`default_nettype wire

// ---- test/ppss_link_partner.sv ----
// ppss_link_partner: far-end transceiver, seen as media status lines.
// assumes the bench picks the line condition; outputs follow it at once.
`default_nettype none
module ppss_link_partner (
  input  wire logic [1:0] mode,
  output logic            energy_det,
  output logic            lps_rx_valid,
  output logic            quiet_rx,
  output logic            non_quiet_rx,
  output logic            frame_rx,
  output logic            rx_activity
);
  timeunit 1ns;
  timeprecision 1ns;
  // 0 quiet line, 1 idle symbols, 2 sleep code-groups, 3 frame traffic
  // combinational so a change lands before the next sampling edge
  assign quiet_rx     = (mode == 2'h0);
  assign energy_det   = (mode != 2'h0);
  assign non_quiet_rx = (mode != 2'h0);
  assign rx_activity  = (mode != 2'h0);
  assign lps_rx_valid = (mode == 2'h2);
  assign frame_rx     = (mode == 2'h3);
endmodule : ppss_link_partner
`default_nettype wire

// ---- test/ppss_sequencer_tb.sv ----
// ppss_sequencer_tb: directed checks of the power-state sequencer.
// assumes shortened timers; inputs change on falling edges only.
`default_nettype none
module ppss_sequencer_tb
  import ppss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SRQ = 20;
  localparam int SIL = 40;
  logic        clk, rst_n, wake, strap, por_done, tx_act, reg_wr, reg_rd, fr_tx;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0]  st_q;
  logic [1:0]  mode;
  logic        pcs_en, lps_tx, quiet_tx, mgmt, en_det, lps_rx, q_rx, nq_rx, fr_rx, rx_act;
  int          bad_count, cmp_count, cycles, n;

  ppss_sequencer #(.SLEEP_RQST_CYCLES(SRQ), .SILENT_CYCLES(SIL)) u_dut (
    .clk(clk), .rst_n(rst_n), .wake_pin(wake), .auton_strap_pin(strap),
    .por_done(por_done), .energy_det(en_det), .lps_rx_valid(lps_rx), .quiet_rx(q_rx),
    .non_quiet_rx(nq_rx), .frame_tx(fr_tx), .frame_rx(fr_rx), .tx_activity(tx_act),
    .rx_activity(rx_act), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .power_state(st_q),
    .pcs_pma_en(pcs_en), .lps_tx_en(lps_tx), .send_quiet(quiet_tx), .mgmt_avail(mgmt));
  ppss_link_partner u_peer (
    .mode(mode), .energy_det(en_det), .lps_rx_valid(lps_rx), .quiet_rx(q_rx),
    .non_quiet_rx(nq_rx), .frame_rx(fr_rx), .rx_activity(rx_act));

  // 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard, far above the planned run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // a timer span judged within a small window around its nominal count
  task automatic near(input int c);
    chk(16'(n >= c - 2 && n <= c + 1), 16'h0001);
  endtask : near
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask : rd
  // wait for a state, bounded, then compare it
  task automatic go(input logic [2:0] s, input int lim);
    n = 0;
    while (st_q !== s && n <= lim) begin
      @(negedge clk);
      n++;
    end
    chk({13'h0000, st_q}, {13'h0000, s});
  endtask : go
  task automatic do_reset(input logic s);
    @(negedge clk);
    rst_n = 1'b0;
    strap = s;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
  endtask : do_reset

  task automatic t_force();
    rd(PPSS_AUTO_OFS, PPSS_AUTO_RST);
    rd(PPSS_LCFG_OFS, PPSS_LCFG_RST);
    rd(16'h0100, 16'h0000);
    chk({13'h0000, st_q}, 16'h0000);
    wr(PPSS_POWER_MODE_CONTROL_OFS, 16'h0001);
    go(PPSS_NORMAL, 4);
    chk(16'(pcs_en), 16'h0001);
    $display("test force normal done");
  endtask : t_force
  task automatic t_lps();
    wr(PPSS_LCTL2_OFS, 16'h0001);
    wr(PPSS_LCFG_OFS, 16'h0300);
    wr(PPSS_AUTO_OFS, 16'h0003);
    mode = 2'h2;
    go(PPSS_SLPREQ, 4);
    mode = 2'h3;
    go(PPSS_NORMAL, 4);
    mode = 2'h2;
    go(PPSS_SLPREQ, 4);
    fr_tx = 1'b1;
    go(PPSS_NORMAL, 4);
    fr_tx = 1'b0;
    wake = 1'b1;
    mode = 2'h2;
    go(PPSS_SLPREQ, 4);
    repeat (SRQ + 5) @(negedge clk);
    chk({13'h0000, st_q}, 16'h0002);
    wake = 1'b0;
    go(PPSS_SILENT, 6);
    go(PPSS_STANDBY, 3);
    mode = 2'h0;
    $display("test sleep request exits done");
  endtask : t_lps
  task automatic t_sleep();
    wr(PPSS_POWER_MODE_CONTROL_OFS, 16'h0001);
    go(PPSS_NORMAL, 4);
    mode = 2'h2;
    go(PPSS_SLPREQ, 4);
    go(PPSS_SILENT, SRQ + 5);
    mode = 2'h0;
    tx_act = 1'b1;
    near(SRQ);
    go(PPSS_SLEEP, SIL + 5);
    near(SIL);
    chk(16'(mgmt), 16'h0000);
    rd(PPSS_AUTO_OFS, 16'h0000);
    tx_act = 1'b0;
    wake = 1'b1;
    go(PPSS_STANDBY, 6);
    wake = 1'b0;
    rd(PPSS_AUTO_OFS, PPSS_AUTO_RST);
    $display("test silent to sleep done");
  endtask : t_sleep
  task automatic t_quiet();
    wr(PPSS_AUTO_OFS, 16'h0001);
    wr(PPSS_POWER_MODE_CONTROL_OFS, 16'h0001);
    go(PPSS_NORMAL, 4);
    mode = 2'h1;
    wr(PPSS_POWER_MODE_CONTROL_OFS, 16'h0002);
    go(PPSS_SLPREQ, 4);
    chk(16'(lps_tx), 16'h0001);
    mode = 2'h0;
    go(PPSS_SILENT, 3);
    chk(16'(quiet_tx), 16'h0001);
    go(PPSS_STANDBY, SIL + 5);
    near(SIL);
    mode = 2'h1;
    go(PPSS_NORMAL, 4);
    mode = 2'h0;
    // sleep enabled, sleep transmit off: no activity in silent sleeps at once
    wr(PPSS_AUTO_OFS, 16'h0002);
    wr(PPSS_POWER_MODE_CONTROL_OFS, 16'h0002);
    go(PPSS_SLPREQ, 4);
    chk(16'(lps_tx), 16'h0000);
    go(PPSS_SILENT, 2);
    go(PPSS_SLEEP, 2);
    rd(PPSS_POWER_MODE_CONTROL_OFS, 16'h0000);
    mode = 2'h1;
    go(PPSS_STANDBY, 3);
    mode = 2'h0;
    chk(16'(mgmt), 16'h0001);
    $display("test quiet and energy done");
  endtask : t_quiet
  task automatic t_auton();
    do_reset(1'b0);
    wr(PPSS_AUTO_OFS, 16'h0042);
    go(PPSS_NORMAL, 4);
    do_reset(1'b1);
    go(PPSS_NORMAL, 8);
    $display("test autonomous start done");
  endtask : t_auton

  // all inputs defined at time zero, reset held 4 cycles
  initial begin
    {bad_count, cmp_count} = '0;
    {wake, strap, tx_act, reg_wr, reg_rd, rst_n, fr_tx} = '0;
    por_done = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    mode = 2'h0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_force();
    t_lps();
    t_sleep();
    t_quiet();
    t_auton();
    end_sim();
  end
endmodule : ppss_sequencer_tb
`default_nettype wire
